/* rtl/efpa_ctrl.sv */
// external master that runs read and write bus cycles on the flash port
`timescale 1ns/100ps
// Notes on behaviour
// - top one, two or three address lines are forced low by density
// - this master drives the data bus in command and write cycles
// - flash reset pin is released to high impedance when flash unused
// - output enable driven low for read cycles, enabling flash drivers
// - write strobe pulsed low once per write cycle
// - start only once internal controller released bus and is held in reset
// - protection commands are ordinary command writes through this port
module efpa_ctrl
  import efpa_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // user side
  input wire logic i_use_flash,
  input wire logic i_bus_free,
  input wire logic [1:0] i_density,
  input wire logic i_req_valid,
  input wire efpa_req_t i_req,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_config_hold_n,
  // flash pins
  output efpa_pins_t o_pins,
  output logic o_flash_reset_oe_n,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe_n,
  input wire logic [DATA_W-1:0] i_dq
);
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RDWAIT} efpa_state_t;

  function automatic logic [ADDR_W-1:0] efpa_mask(input logic [1:0] d,
                                                  input logic [ADDR_W-1:0] a);
    unique case (d)
      DENS_8M: efpa_mask = a & AMASK_8M;
      DENS_4M: efpa_mask = a & AMASK_4M;
      default: efpa_mask = a & AMASK_16M;
    endcase
  endfunction

  // phase lengths are whole cycles; the counter runs down to zero
  function automatic logic [CNT_W-1:0] efpa_load(input int cyc);
    efpa_load = CNT_W'(cyc - 1);
  endfunction

  function automatic logic [CNT_W-1:0] efpa_dec(input logic [CNT_W-1:0] c);
    efpa_dec = c - 1'b1;
  endfunction

  efpa_state_t st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  efpa_pins_t pins_r, pins_nxt;
  logic rst_oe_n_r, rst_oe_n_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt;
  logic dq_oe_n_r, dq_oe_n_nxt;
  logic ready_r, ready_nxt;
  logic rdv_r, rdv_nxt;
  logic [DATA_W-1:0] rdd_r, rdd_nxt;
  logic hold_n_r, hold_n_nxt;

  // bus ownership follows the user request directly, no sequencing needed
  always_comb begin
    // keep the internal controller in reset whenever we want the bus
    hold_n_nxt = ~i_use_flash;
    // release reset pin when not using flash, else drive it high
    rst_oe_n_nxt = ~i_use_flash;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_oe_n_r <= 1'b1;
      hold_n_r <= 1'b1;
    end else begin
      rst_oe_n_r <= rst_oe_n_nxt;
      hold_n_r <= hold_n_nxt;
    end
  end

  // one cycle of grace so ready never overlaps a started cycle
  always_comb begin
    ready_nxt = 1'b0;
    if (st_r == ST_IDLE && !ready_r) begin
      ready_nxt = i_use_flash & i_bus_free;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  // read data sampled once at the end of the access time, then held
  always_comb begin
    rdv_nxt = 1'b0;
    rdd_nxt = rdd_r;
    if (st_r == ST_RDWAIT && cnt_r == '0) begin
      rdd_nxt = i_dq;
      rdv_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdv_r <= 1'b0;
      rdd_r <= '0;
    end else begin
      rdv_r <= rdv_nxt;
      rdd_r <= rdd_nxt;
    end
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    pins_nxt = pins_r;
    dq_nxt = dq_r;
    dq_oe_n_nxt = dq_oe_n_r;
    pins_nxt.flash_reset_n = 1'b1;
    unique case (st_r)
      ST_IDLE: begin
        pins_nxt.ce_n = 1'b1;
        pins_nxt.oe_n = 1'b1;
        pins_nxt.we_n = 1'b1;
        dq_oe_n_nxt = 1'b1;
        if (ready_r && i_req_valid) begin
          wr_nxt = i_req.write;
          pins_nxt.addr = efpa_mask(i_density, i_req.addr);
          pins_nxt.ce_n = 1'b0;
          dq_nxt = i_req.data;
          // writes drive data; reads leave the bus released
          dq_oe_n_nxt = ~i_req.write;
          cnt_nxt = efpa_load(T_SETUP_CYC);
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_r == '0) begin
          if (wr_r) begin
            pins_nxt.we_n = 1'b0;
            cnt_nxt = efpa_load(T_STROBE_CYC);
            st_nxt = ST_STROBE;
          end else begin
            // data bus already released before output enable
            pins_nxt.oe_n = 1'b0;
            cnt_nxt = efpa_load(T_RDACC_CYC);
            st_nxt = ST_RDWAIT;
          end
        end else begin
          cnt_nxt = efpa_dec(cnt_r);
        end
      end
      ST_STROBE: begin
        if (cnt_r == '0) begin
          // address and data held stable across the rising edge
          pins_nxt.we_n = 1'b1;
          cnt_nxt = efpa_load(T_HOLD_CYC);
          st_nxt = ST_HOLD;
        end else begin
          cnt_nxt = efpa_dec(cnt_r);
        end
      end
      ST_RDWAIT: begin
        if (cnt_r == '0) begin
          pins_nxt.oe_n = 1'b1;
          cnt_nxt = efpa_load(T_HOLD_CYC);
          st_nxt = ST_HOLD;
        end else begin
          cnt_nxt = efpa_dec(cnt_r);
        end
      end
      ST_HOLD: begin
        if (cnt_r == '0) begin
          pins_nxt.ce_n = 1'b1;
          dq_oe_n_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end else begin
          cnt_nxt = efpa_dec(cnt_r);
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
      pins_r <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, flash_reset_n: 1'b1};
      dq_r <= '0;
      dq_oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      pins_r <= pins_nxt;
      dq_r <= dq_nxt;
      dq_oe_n_r <= dq_oe_n_nxt;
    end
  end

  // write protect has no port here at all
  assign o_pins = pins_r;
  assign o_flash_reset_oe_n = rst_oe_n_r;
  assign o_dq = dq_r;
  assign o_dq_oe_n = dq_oe_n_r;
  assign o_req_ready = ready_r;
  assign o_rd_valid = rdv_r;
  assign o_rd_data = rdd_r;
  assign o_config_hold_n = hold_n_r;
endmodule // efpa_ctrl

/* shared/efpa_pkg.sv */
// package for the external flash port controller: widths, timing, carriers
package efpa_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 25;
  // bus cycle phase lengths in ns, counted in 40 ns cycles
  localparam int T_SETUP_NS = 80;
  localparam int T_STROBE_NS = 120;
  localparam int T_HOLD_NS = 80;
  localparam int T_RDACC_NS = 160;
  localparam int T_SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RDACC_CYC = (T_RDACC_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 4;
  // density selection codes
  localparam logic [1:0] DENS_16M = 2'h0;
  localparam logic [1:0] DENS_8M = 2'h1;
  localparam logic [1:0] DENS_4M = 2'h2;
  localparam logic [ADDR_W-1:0] AMASK_16M = 21'h0FFFFF;
  localparam logic [ADDR_W-1:0] AMASK_8M = 21'h07FFFF;
  localparam logic [ADDR_W-1:0] AMASK_4M = 21'h03FFFF;

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } efpa_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic flash_reset_n;
  } efpa_pins_t;
endpackage

/* bench/efpa_flash_model.sv */
// behavioural flash array on the far side of the port
`timescale 1ns/100ps
module efpa_flash_model import efpa_pkg::*; (
  // pins from the master
  input wire efpa_pins_t i_pins,
  input wire logic i_rst_oe_n,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic i_dq_oe_n,
  // data toward the master
  output logic [DATA_W-1:0] o_dq
);
  logic [DATA_W-1:0] mem [int];
  logic off;
  assign off = i_pins.ce_n | i_rst_oe_n | !i_pins.flash_reset_n;
  initial o_dq = 16'h5A5A;
  always @(posedge i_pins.we_n) begin
    if (!off && !i_dq_oe_n) mem[int'(i_pins.addr)] = i_dq;
  end
  // released bus flips each change so a stale value never reads as good
  always @(i_pins or off) begin
    o_dq = (!off && !i_pins.oe_n) ? mem[int'(i_pins.addr)] : ~o_dq;
  end
endmodule // efpa_flash_model

/* bench/efpa_ctrl_monitor.sv */
// checker: timing relations on the flash port
`timescale 1ns/100ps
module efpa_ctrl_monitor import efpa_pkg::*; (
  // user side
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_use_flash,
  input wire logic i_bus_free,
  input wire logic i_req_valid,
  input wire efpa_req_t i_req,
  input wire logic o_req_ready,
  input wire logic o_rd_valid,
  // flash pins
  input wire efpa_pins_t o_pins,
  input wire logic o_flash_reset_oe_n,
  input wire logic [DATA_W-1:0] o_dq,
  input wire logic o_dq_oe_n
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_rd; o_req_ready && i_req_valid && !i_req.write; endsequence
  sequence s_str; !o_pins.we_n [*3] ##1 o_pins.we_n; endsequence
  AST_RD_LAT: assert property (s_rd |-> ##7 o_rd_valid)
    else $error("read late");
  AST_STROBE: assert property ($fell(o_pins.we_n) |-> s_str)
    else $error("strobe width");
  AST_LATCH:
    assert property ($rose(o_pins.we_n) |-> $stable(o_dq) && $stable(o_pins.addr) &&
      !o_pins.ce_n && !o_dq_oe_n)
    else $error("latch edge");
  AST_NO_OVL: assert property (o_pins.oe_n || o_pins.we_n)
    else $error("oe with we");
  AST_RD_REL: assert property (!o_pins.oe_n |-> o_dq_oe_n)
    else $error("dq clash");
  AST_WR_DRV: assert property (!o_pins.we_n |-> !o_dq_oe_n)
    else $error("dq undriven");
  AST_GATE:
    assert property (o_req_ready |-> $past(i_use_flash) && $past(i_bus_free))
    else $error("ready early");
  AST_ADDR_TOP: assert property (!o_pins.ce_n |-> !o_pins.addr[ADDR_W-1])
    else $error("top address line set");
  AST_RP_HIGH: assert property (!o_flash_reset_oe_n |-> o_pins.flash_reset_n)
    else $error("flash reset driven low");
  AST_RP_REL: assert property (!$past(i_use_flash) |-> o_flash_reset_oe_n)
    else $error("reset pin held");
endmodule // efpa_ctrl_monitor
bind efpa_ctrl efpa_ctrl_monitor u_mon (.i_core_clk, .i_nrst, .i_use_flash, .i_bus_free,
  .i_req_valid, .i_req, .o_req_ready, .o_rd_valid, .o_pins, .o_flash_reset_oe_n, .o_dq,
  .o_dq_oe_n);

/* bench/testbench.sv */
// self-checking bench for the flash port master
`timescale 1ns/100ps
module testbench import efpa_pkg::*; ;
  typedef struct packed {logic w; logic [1:0] dn; logic [20:0] a; logic [15:0] d;} efpa_row_t;
  logic clk = 0, nrst = 0, use_f = 1, free = 1, vld = 0, rdv, rdy, hold_n, rst_oe_n, moe_n;
  logic [1:0] dens = 2'h0;
  logic [DATA_W-1:0] rdd, mdq, fdq, dq;
  efpa_req_t req = '0;
  efpa_pins_t pins;
  int fails = 0, cmp_count = 0;
  // upper lines set in writes must be dropped by the density mask
  efpa_row_t rows [6] = '{'{1'h1, 2'h2, 21'h1C0020, 16'hA55A},
    '{1'h1, 2'h1, 21'h1FFFFF, 16'h1234}, '{1'h0, 2'h0, 21'h000020, 16'hA55A},
    '{1'h0, 2'h0, 21'h07FFFF, 16'h1234}, '{1'h0, 2'h3, 21'h17FFFF, 16'h1234},
    '{1'h0, 2'h2, 21'h1C0020, 16'hA55A}};
  always #20 clk = ~clk;
  assign dq = moe_n ? fdq : mdq;
  efpa_ctrl u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_use_flash(use_f), .i_bus_free(free),
    .i_density(dens), .i_req_valid(vld), .i_req(req), .o_req_ready(rdy), .o_rd_valid(rdv),
    .o_rd_data(rdd), .o_config_hold_n(hold_n), .o_pins(pins), .o_flash_reset_oe_n(rst_oe_n),
    .o_dq(mdq), .o_dq_oe_n(moe_n), .i_dq(dq));
  efpa_flash_model u_flash (.i_pins(pins), .i_rst_oe_n(rst_oe_n), .i_dq(dq),
    .i_dq_oe_n(moe_n), .o_dq(fdq));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic op(input efpa_row_t r);
    int n;
    n = 0;
    dens <= r.dn;
    req <= '{r.w, r.a, r.d};
    vld <= 1'h1;
    do begin @(posedge clk); n++; end while (rdy !== 1'h1 && n < 40);
    if (rdy !== 1'h1) begin
      fails++;
      $display("ERROR %0t no ready", $time);
      complete_run();
    end
    vld <= 1'h0;
    while (!r.w && rdv !== 1'h1 && n < 60) begin @(posedge clk); n++; end
    if (!r.w && rdv !== 1'h1) begin
      fails++;
      $display("ERROR %0t no read data", $time);
      complete_run();
    end
    if (!r.w) chk(rdd, r.d);
    repeat (12) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    chk({pins.ce_n, pins.oe_n, pins.we_n, rst_oe_n, rdy}, 16'h1E);
    nrst <= 1'h1;
    foreach (rows[i]) op(rows[i]);
    free <= 1'h0;
    repeat (4) @(posedge clk);
    vld <= 1'h1;
    repeat (20) begin @(posedge clk); chk({rdy, hold_n, rst_oe_n}, 16'h0); end
    vld <= 1'h0;
    use_f <= 1'h0;
    repeat (3) @(posedge clk);
    chk({rst_oe_n, hold_n}, 16'h3);
    complete_run();
  end
endmodule // testbench
